/* common/scec_map.vh */
// register map, field positions and reset values of the system control event block
`ifndef SCEC_MAP_VH
`define SCEC_MAP_VH

// register byte offsets
`define SCEC_FLASH_SIZE_OFS 8'h00
`define SCEC_PORT_HS_EN_OFS 8'h04
`define SCEC_MCLK_IN_OFS 8'h08
`define SCEC_MCLK_REQ_OFS 8'h0C
`define SCEC_MCLK_DIV_OFS 8'h10
`define SCEC_MCLK_STAT_OFS 8'h14
`define SCEC_LDO_VSEL_OFS 8'h18
`define SCEC_INT_STATUS_OFS 8'h20
`define SCEC_INT_MASKED_OFS 8'h24
`define SCEC_INT_EN_OFS 8'h28
`define SCEC_INT_EN_SET_OFS 8'h2C
`define SCEC_INT_EN_CLR_OFS 8'h30
`define SCEC_INT_CLR_OFS 8'h34
`define SCEC_INT_VIEW_OFS 8'h38

// event bit positions
`define SCEC_EVT_PLL_LOCKED 0
`define SCEC_EVT_CURRENT_LIMIT 1
`define SCEC_EVT_INTERNAL_OSC_FAIL 2
`define SCEC_EVT_MAIN_OSC_FAIL 3
`define SCEC_EVT_POWER_ON 4
`define SCEC_EVT_BROWN_OUT 5
`define SCEC_EVT_PLL_FAILURE 6
`define SCEC_EVT_NUM 7

// audio clock status bits
`define SCEC_MCLK_STAT_BUSY 0
`define SCEC_MCLK_STAT_RUN 1

// regulator code 0..10 is 2.25 V..2.75 V in 50 mV steps
`define SCEC_LDO_CODE_MAX 4'hA
`define SCEC_LDO_CODE_RST 4'h5

// reset values
`define SCEC_FLASH_BYTES 32'h0004_0000
`define SCEC_PORT_HS_EN_RST 8'h00
`define SCEC_INT_EN_RST 7'h00
`define SCEC_SYS_CLK_HZ 32'h0262_5A00

// port apertures: bits 31:15 tag, bits 14:12 port index
`define SCEC_LEG_APT_TAG 17'h0_8000
`define SCEC_HS_APT_TAG 17'h0_8010

// divider iterations
`define SCEC_DIV_STEPS 6'h20

`endif

/* design/scec_evt_bit.v */
// sticky event flag: a new event wins over a clear in the same cycle
module scec_evt_bit (
  input wire clk_i,
  input wire rst_n_i,
  input wire set_i,
  input wire clr_i,
  output wire q_o
);

  reg flag_q;
  reg flag_d;

  always @* begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  // holds until cleared
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign q_o = flag_q;

endmodule // scec_evt_bit

/* design/scec_top.v */
// system control: event flags, interrupt, port aperture select, audio clock divider, regulator setting
`include "scec_map.vh"

module scec_top #(
  parameter [31:0] FLASH_BYTES = `SCEC_FLASH_BYTES,
  parameter [31:0] SYS_CLK_HZ = `SCEC_SYS_CLK_HZ
) (
  input wire CLK_I,
  input wire RST_N_I,
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  input wire PLL_LOCKED_EVENT_I,
  input wire CURRENT_LIMIT_EVENT_I,
  input wire INTERNAL_OSC_FAIL_EVENT_I,
  input wire MAIN_OSC_FAIL_EVENT_I,
  input wire POWER_ON_EVENT_I,
  input wire BROWN_OUT_EVENT_I,
  input wire PLL_FAILURE_EVENT_I,
  output reg IRQ_O,
  input wire [31:0] PORT_ACC_ADDR_I,
  input wire PORT_ACC_VALID_I,
  output reg [7:0] PORT_HIT_O,
  output reg PORT_HIT_HS_O,
  output reg [7:0] PORT_HS_EN_O,
  output reg AUDIO_MCLK_O,
  output reg AUDIO_MCLK_EN_O,
  output reg [3:0] LDO_VSEL_O
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_DIV = 2'b01;
  localparam [1:0] ST_ROUND = 2'b10;

  // register decode
  wire wr_port_hs = WR_I && (ADDR_I == `SCEC_PORT_HS_EN_OFS);
  wire wr_mclk_in = WR_I && (ADDR_I == `SCEC_MCLK_IN_OFS);
  wire wr_mclk_req = WR_I && (ADDR_I == `SCEC_MCLK_REQ_OFS);
  wire wr_ldo = WR_I && (ADDR_I == `SCEC_LDO_VSEL_OFS);
  wire wr_int_en = WR_I && (ADDR_I == `SCEC_INT_EN_OFS);
  wire wr_int_en_set = WR_I && (ADDR_I == `SCEC_INT_EN_SET_OFS);
  wire wr_int_en_clr = WR_I && (ADDR_I == `SCEC_INT_EN_CLR_OFS);
  wire wr_int_clr = WR_I && (ADDR_I == `SCEC_INT_CLR_OFS);
  wire wr_int_view = WR_I && (ADDR_I == `SCEC_INT_VIEW_OFS);

  // event flags
  wire [6:0] evt_pulse;
  wire [6:0] evt_flag;
  reg [6:0] int_en_q;
  reg [6:0] int_en_d;
  reg masked_view_select_q;

  assign evt_pulse[`SCEC_EVT_PLL_LOCKED] = PLL_LOCKED_EVENT_I;
  assign evt_pulse[`SCEC_EVT_CURRENT_LIMIT] = CURRENT_LIMIT_EVENT_I;
  assign evt_pulse[`SCEC_EVT_INTERNAL_OSC_FAIL] = INTERNAL_OSC_FAIL_EVENT_I;
  assign evt_pulse[`SCEC_EVT_MAIN_OSC_FAIL] = MAIN_OSC_FAIL_EVENT_I;
  assign evt_pulse[`SCEC_EVT_POWER_ON] = POWER_ON_EVENT_I;
  assign evt_pulse[`SCEC_EVT_BROWN_OUT] = BROWN_OUT_EVENT_I;
  assign evt_pulse[`SCEC_EVT_PLL_FAILURE] = PLL_FAILURE_EVENT_I;

  genvar gi;
  generate
    for (gi = 0; gi < `SCEC_EVT_NUM; gi = gi + 1) begin : g_evt
      scec_evt_bit u_evt (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .set_i(evt_pulse[gi]),
        .clr_i(wr_int_clr && WDATA_I[gi]),
        .q_o(evt_flag[gi])
      );
    end
  endgenerate

  wire [6:0] evt_masked = evt_flag & int_en_q;

  // enable bits: plain write, set-mask and clear-mask
  always @* begin
    int_en_d = int_en_q;
    if (wr_int_en) begin
      int_en_d = WDATA_I[6:0];
    end
    if (wr_int_en_set) begin
      int_en_d = int_en_q | WDATA_I[6:0];
    end
    if (wr_int_en_clr) begin
      int_en_d = int_en_q & ~WDATA_I[6:0];
    end
  end

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      int_en_q <= `SCEC_INT_EN_RST;
      masked_view_select_q <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      int_en_q <= int_en_d;
      if (wr_int_view) begin
        masked_view_select_q <= WDATA_I[0];
      end
      IRQ_O <= |evt_masked;
    end
  end

  // port aperture select
  wire [2:0] acc_idx = PORT_ACC_ADDR_I[14:12];
  wire acc_leg = PORT_ACC_ADDR_I[31:15] == `SCEC_LEG_APT_TAG;
  wire acc_hs = PORT_ACC_ADDR_I[31:15] == `SCEC_HS_APT_TAG;
  wire acc_on = PORT_HS_EN_O[acc_idx];
  wire hit_leg = PORT_ACC_VALID_I && acc_leg && !acc_on;
  wire hit_hs = PORT_ACC_VALID_I && acc_hs && acc_on;
  reg [7:0] port_hit_d;

  always @* begin
    port_hit_d = 8'h00;
    if (hit_leg || hit_hs) begin
      port_hit_d[acc_idx] = 1'b1;
    end
  end

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PORT_HS_EN_O <= `SCEC_PORT_HS_EN_RST;
      PORT_HIT_O <= 8'h00;
      PORT_HIT_HS_O <= 1'b0;
    end else begin
      if (wr_port_hs) begin
        PORT_HS_EN_O <= WDATA_I[7:0];
      end
      PORT_HIT_O <= port_hit_d;
      PORT_HIT_HS_O <= hit_hs;
    end
  end

  // regulator setting, codes above the top step are refused
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LDO_VSEL_O <= `SCEC_LDO_CODE_RST;
    end else if (wr_ldo && (WDATA_I[31:4] == 28'h000_0000) && (WDATA_I[3:0] <= `SCEC_LDO_CODE_MAX)) begin
      LDO_VSEL_O <= WDATA_I[3:0];
    end
  end

  // audio clock divider: restoring division, then round to nearest
  reg [31:0] audio_master_clock_request_q;
  reg [31:0] audio_divider_input_clock_q;
  reg [1:0] state_q;
  reg [32:0] rem_q;
  reg [31:0] dvd_q;
  reg [31:0] quo_q;
  reg [5:0] step_q;
  reg [31:0] div_q;
  reg [31:0] mclk_cnt_q;
  reg run_q;

  wire start_div = wr_mclk_req || wr_mclk_in;
  wire [31:0] new_req = wr_mclk_req ? WDATA_I : audio_master_clock_request_q;
  wire [31:0] new_in = wr_mclk_in ? WDATA_I : audio_divider_input_clock_q;
  wire [31:0] eff_in = (new_in == 32'h0000_0000) ? SYS_CLK_HZ : new_in;
  wire [32:0] rem_sh = {rem_q[31:0], dvd_q[31]};
  wire rem_ge = rem_sh >= {1'b0, audio_master_clock_request_q};
  wire [32:0] rem_x2 = {rem_q[31:0], 1'b0};
  wire round_up = rem_x2 >= {1'b0, audio_master_clock_request_q};
  wire [31:0] quo_rnd = round_up ? quo_q + 32'h0000_0001 : quo_q;
  wire [31:0] half_div = {1'b0, div_q[31:1]};
  wire [31:0] last_cnt = div_q - 32'h0000_0001;

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      audio_master_clock_request_q <= 32'h0000_0000;
      audio_divider_input_clock_q <= 32'h0000_0000;
      state_q <= ST_IDLE;
      rem_q <= 33'h0_0000_0000;
      dvd_q <= 32'h0000_0000;
      quo_q <= 32'h0000_0000;
      step_q <= 6'h00;
      div_q <= 32'h0000_0001;
      run_q <= 1'b0;
    end else begin
      if (wr_mclk_req) begin
        audio_master_clock_request_q <= WDATA_I;
      end
      if (wr_mclk_in) begin
        audio_divider_input_clock_q <= WDATA_I;
      end
      if (start_div) begin
        rem_q <= 33'h0_0000_0000;
        dvd_q <= eff_in;
        quo_q <= 32'h0000_0000;
        step_q <= `SCEC_DIV_STEPS;
        if (new_req == 32'h0000_0000) begin
          run_q <= 1'b0;
          state_q <= ST_IDLE;
        end else begin
          state_q <= ST_DIV;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_q <= ST_IDLE;
          end
          ST_DIV: begin
            rem_q <= rem_ge ? rem_sh - {1'b0, audio_master_clock_request_q} : rem_sh;
            quo_q <= {quo_q[30:0], rem_ge};
            dvd_q <= {dvd_q[30:0], 1'b0};
            step_q <= step_q - 6'h01;
            if (step_q == 6'h01) begin
              state_q <= ST_ROUND;
            end
          end
          ST_ROUND: begin
            div_q <= (quo_rnd == 32'h0000_0000) ? 32'h0000_0001 : quo_rnd;
            run_q <= 1'b1;
            state_q <= ST_IDLE;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // output clock: period div_q system cycles
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mclk_cnt_q <= 32'h0000_0000;
      AUDIO_MCLK_O <= 1'b0;
      AUDIO_MCLK_EN_O <= 1'b0;
    end else begin
      AUDIO_MCLK_EN_O <= run_q;
      if (!run_q || (state_q == ST_ROUND)) begin
        mclk_cnt_q <= 32'h0000_0000;
        AUDIO_MCLK_O <= 1'b0;
      end else begin
        if (mclk_cnt_q >= last_cnt) begin
          mclk_cnt_q <= 32'h0000_0000;
        end else begin
          mclk_cnt_q <= mclk_cnt_q + 32'h0000_0001;
        end
        AUDIO_MCLK_O <= mclk_cnt_q >= half_div;
      end
    end
  end

  // read port: data stands only in the cycle after the strobe
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (ADDR_I)
      `SCEC_FLASH_SIZE_OFS: begin
        rd_mux = FLASH_BYTES;
      end
      `SCEC_PORT_HS_EN_OFS: begin
        rd_mux = {24'h00_0000, PORT_HS_EN_O};
      end
      `SCEC_MCLK_IN_OFS: begin
        rd_mux = audio_divider_input_clock_q;
      end
      `SCEC_MCLK_REQ_OFS: begin
        rd_mux = audio_master_clock_request_q;
      end
      `SCEC_MCLK_DIV_OFS: begin
        rd_mux = run_q ? div_q : 32'h0000_0000;
      end
      `SCEC_MCLK_STAT_OFS: begin
        rd_mux[`SCEC_MCLK_STAT_BUSY] = state_q != ST_IDLE;
        rd_mux[`SCEC_MCLK_STAT_RUN] = run_q;
      end
      `SCEC_LDO_VSEL_OFS: begin
        rd_mux = {28'h000_0000, LDO_VSEL_O};
      end
      `SCEC_INT_STATUS_OFS: begin
        rd_mux = {25'h000_0000, masked_view_select_q ? evt_masked : evt_flag};
      end
      `SCEC_INT_MASKED_OFS: begin
        rd_mux = {25'h000_0000, evt_masked};
      end
      `SCEC_INT_EN_OFS: begin
        rd_mux = {25'h000_0000, int_en_q};
      end
      `SCEC_INT_VIEW_OFS: begin
        rd_mux = {31'h0000_0000, masked_view_select_q};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (RD_I) begin
      RDATA_O <= rd_mux;
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

endmodule // scec_top

/* bench/scec_chk.sv */
// assertion checker for the system control event block
module scec_chk #(
  parameter [31:0] FLASH_BYTES = 32'h0004_0000
) (
  input wire CLK_I,
  input wire RST_N_I,
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [31:0] RDATA_O,
  input wire PLL_LOCKED_EVENT_I,
  input wire CURRENT_LIMIT_EVENT_I,
  input wire INTERNAL_OSC_FAIL_EVENT_I,
  input wire MAIN_OSC_FAIL_EVENT_I,
  input wire POWER_ON_EVENT_I,
  input wire BROWN_OUT_EVENT_I,
  input wire PLL_FAILURE_EVENT_I,
  input wire IRQ_O,
  input wire [31:0] PORT_ACC_ADDR_I,
  input wire PORT_ACC_VALID_I,
  input wire [7:0] PORT_HIT_O,
  input wire PORT_HIT_HS_O,
  input wire AUDIO_MCLK_O,
  input wire AUDIO_MCLK_EN_O,
  input wire [3:0] LDO_VSEL_O
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [6:0] evt = {PLL_FAILURE_EVENT_I, BROWN_OUT_EVENT_I, POWER_ON_EVENT_I, MAIN_OSC_FAIL_EVENT_I,
    INTERNAL_OSC_FAIL_EVENT_I, CURRENT_LIMIT_EVENT_I, PLL_LOCKED_EVENT_I};
  wire [2:0] pn = PORT_ACC_ADDR_I[14:12];
  wire [16:0] tag = PORT_ACC_ADDR_I[31:15];
  reg view_q;
  reg [7:0] hs_q;
  wire hb = hs_q[pn];
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // shadow of view select and port high-speed enables
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      view_q <= 1'b0;
      hs_q <= 8'h00;
    end else if (WR_I && ADDR_I == 8'h38) begin
      view_q <= WDATA_I[0];
    end else if (WR_I && ADDR_I == 8'h04) begin
      hs_q <= WDATA_I[7:0];
    end
  end
  sequence evt_then_raw_read;
    evt != 7'h00 ##1 (RD_I && ADDR_I == 8'h20 && !view_q);
  endsequence
  sequence clear_all_quiet;
    (WR_I && ADDR_I == 8'h34 && WDATA_I[6:0] == 7'h7F && evt == 7'h00) ##1 evt == 7'h00;
  endsequence
  chk_flash_read: assert property (RD_I && ADDR_I == 8'h00 |=> RDATA_O == FLASH_BYTES)
    else $error("flash size read wrong");
  chk_event_sticky: assert property (evt_then_raw_read |=> (RDATA_O[6:0] & $past(evt, 2)) == $past(evt, 2))
    else $error("event flag not set");
  chk_clear_irq_low: assert property (clear_all_quiet |=> !IRQ_O)
    else $error("interrupt stays after clear");
  chk_hs_window: assert property (PORT_ACC_VALID_I && tag == 17'h0_8010 |=>
    PORT_HIT_HS_O == $past(hb) && PORT_HIT_O == ($past(hb) ? 8'h01 << $past(pn) : 8'h00))
    else $error("high-speed aperture hit wrong");
  chk_legacy_window: assert property (PORT_ACC_VALID_I && tag == 17'h0_8000 |=>
    !PORT_HIT_HS_O && PORT_HIT_O == ($past(hb) ? 8'h00 : 8'h01 << $past(pn)))
    else $error("legacy aperture hit wrong");
  chk_ldo_in_range: assert property (LDO_VSEL_O <= 4'hA)
    else $error("regulator code out of range");
  chk_ldo_reset: assert property ($rose(RST_N_I) |-> LDO_VSEL_O == 4'h5)
    else $error("regulator reset code wrong");
  chk_mclk_stop: assert property (WR_I && ADDR_I == 8'h0C && WDATA_I == 32'h0 |-> ##2 !AUDIO_MCLK_EN_O && !AUDIO_MCLK_O)
    else $error("audio clock not stopped");
endmodule // scec_chk

bind scec_top scec_chk #(.FLASH_BYTES(FLASH_BYTES)) scec_chk_u (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .PLL_LOCKED_EVENT_I(PLL_LOCKED_EVENT_I), .CURRENT_LIMIT_EVENT_I(CURRENT_LIMIT_EVENT_I),
  .INTERNAL_OSC_FAIL_EVENT_I(INTERNAL_OSC_FAIL_EVENT_I), .MAIN_OSC_FAIL_EVENT_I(MAIN_OSC_FAIL_EVENT_I),
  .POWER_ON_EVENT_I(POWER_ON_EVENT_I), .BROWN_OUT_EVENT_I(BROWN_OUT_EVENT_I),
  .PLL_FAILURE_EVENT_I(PLL_FAILURE_EVENT_I), .IRQ_O(IRQ_O), .PORT_ACC_ADDR_I(PORT_ACC_ADDR_I),
  .PORT_ACC_VALID_I(PORT_ACC_VALID_I), .PORT_HIT_O(PORT_HIT_O), .PORT_HIT_HS_O(PORT_HIT_HS_O),
  .AUDIO_MCLK_O(AUDIO_MCLK_O), .AUDIO_MCLK_EN_O(AUDIO_MCLK_EN_O), .LDO_VSEL_O(LDO_VSEL_O));

/* bench/tb.sv */
// self-checking bench for the system control event block
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [6:0] ev = 7'h00;
  reg [31:0] pa = 32'h0;
  reg pv = 1'b0;
  wire [31:0] rdata;
  wire irq, hit_hs, mclk, mclk_en;
  wire [7:0] hit, hs_en;
  wire [3:0] ldo;
  int miscompares = 0;
  int checks_done = 0;
  int flags, en, hs, lv, i, k, r, n, h;
  int rq[3] = '{11_111_111, 9_090_909, 40_000_000};
  logic [31:0] d;
  scec_top dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .PLL_LOCKED_EVENT_I(ev[0]), .CURRENT_LIMIT_EVENT_I(ev[1]), .INTERNAL_OSC_FAIL_EVENT_I(ev[2]),
    .MAIN_OSC_FAIL_EVENT_I(ev[3]), .POWER_ON_EVENT_I(ev[4]), .BROWN_OUT_EVENT_I(ev[5]),
    .PLL_FAILURE_EVENT_I(ev[6]), .IRQ_O(irq), .PORT_ACC_ADDR_I(pa), .PORT_ACC_VALID_I(pv), .PORT_HIT_O(hit),
    .PORT_HIT_HS_O(hit_hs), .PORT_HS_EN_O(hs_en), .AUDIO_MCLK_O(mclk), .AUDIO_MCLK_EN_O(mclk_en),
    .LDO_VSEL_O(ldo));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr_reg(input [7:0] a, input [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [7:0] a, output [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    rd_reg(a, d);
    `CHK(d, e)
  endtask
  // event pulse with a same-cycle clear, then raw status read
  task pulse(input [6:0] m, input [6:0] c);
    @(posedge clk);
    ev <= m;
    addr <= 8'h34;
    wdata <= {25'h0, c};
    wr <= 1'b1;
    @(posedge clk);
    ev <= 7'h00;
    wr <= 1'b0;
    addr <= 8'h20;
    rd <= 1'b1;
    flags = (flags & ~c) | m;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, flags)
  endtask
  task pchk(input [31:0] a);
    @(posedge clk);
    pa <= a;
    pv <= 1'b1;
    @(posedge clk);
    pv <= 1'b0;
    @(negedge clk);
    n = a[14:12];
    h = (hs[n] && a[31:15] == 17'h0_8010) || (!hs[n] && a[31:15] == 17'h0_8000);
    `CHK(hit, h ? 8'h01 << n : 8'h00)
    `CHK(hit_hs, h && a[31:15] == 17'h0_8010)
  endtask
  initial begin
    #500_000;
    miscompares++;
    results();
  end
  initial begin
    void'($urandom(32'h5168_4450));
    flags = 0;
    en = 0;
    lv = 5;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h00, 32'h0004_0000);
    rchk(8'h18, 32'h5);
    rchk(8'h28, 32'h0);
    rchk(8'h3C, 32'h0);
    `CHK(ldo, 4'h5)
    $display("reset test done");
    wr_reg(8'h28, 32'h55);
    en = 32'h55;
    for (k = 0; k < 10; k++) begin
      pulse((7'h01 << (k % 7)) | 7'($urandom), 7'($urandom));
      r = $urandom_range(127, 0);
      wr_reg(8'h2C, r);
      en = en | r;
      r = $urandom_range(127, 0);
      wr_reg(8'h30, r);
      en = en & ~r;
      rchk(8'h28, en);
      rchk(8'h24, flags & en);
      wr_reg(8'h38, 32'h1);
      rchk(8'h20, flags & en);
      wr_reg(8'h38, 32'h0);
      `CHK(irq, (flags & en) != 0)
      r = $urandom_range(127, 0);
      wr_reg(8'h34, r);
      flags = flags & ~r;
      rchk(8'h20, flags);
      `CHK(irq, (flags & en) != 0)
    end
    wr_reg(8'h34, 32'h7F);
    flags = 0;
    rchk(8'h20, 32'h0);
    `CHK(irq, 1'b0)
    $display("event test done");
    hs = $urandom_range(255, 0);
    wr_reg(8'h04, hs);
    rchk(8'h04, hs);
    `CHK(hs_en, hs[7:0])
    for (i = 0; i < 8; i++) begin
      pchk(32'h4000_0000 + i * 32'h1000);
      pchk(32'h4008_0000 + i * 32'h1000);
    end
    pchk(32'h4001_0000);
    $display("port test done");
    for (i = 0; i < 12; i++) begin
      wr_reg(8'h18, i);
      if (i <= 10) lv = i;
      rchk(8'h18, lv);
      `CHK(ldo, lv[3:0])
    end
    $display("regulator test done");
    wr_reg(8'h08, 32'h0);
    for (i = 0; i < 3; i++) begin
      wr_reg(8'h0C, rq[i]);
      d = 32'h0;
      // wait for the new divisor: busy low and run high
      for (k = 0; k < 60 && !(d[1] === 1'b1 && d[0] === 1'b0); k++) rd_reg(8'h14, d);
      `CHK(d[1:0], 2'b10)
      n = (40_000_000 + rq[i] / 2) / rq[i];
      rchk(8'h10, n);
      `CHK(mclk_en, 1'b1)
      // high count over ten whole periods: low for n/2 counts, then high
      h = 0;
      repeat (10 * n) begin
        @(negedge clk);
        h += mclk;
      end
      `CHK(h, (n - n / 2) * 10)
    end
    wr_reg(8'h0C, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(mclk_en, 1'b0)
    `CHK(mclk, 1'b0)
    rchk(8'h10, 32'h0);
    $display("audio clock test done");
    results();
  end
endmodule // tb
